// ===== adc_reg_pkg.sv
// Register map, command layout and frame constants of the serial register access block
package adc_reg_pkg;
    localparam int          FRAME_BITS      = 16;
    localparam int          CNT_W           = 5;
    localparam logic [4:0]  FRAME_LAST      = 5'h0F;
    localparam int          WR_BIT          = 15;
    localparam int          SEL_HI          = 14;
    localparam int          SEL_LO          = 12;
    localparam int          DATA_W          = 12;
    localparam logic [2:0]  SEL_CONFIG_ONE  = 3'h1;
    localparam logic [2:0]  SEL_CONFIG_TWO  = 3'h2;
    localparam logic [2:0]  SEL_ALERT_FLAGS = 3'h3;
    localparam logic [2:0]  SEL_ALERT_LOW   = 3'h4;
    localparam logic [2:0]  SEL_ALERT_HIGH  = 3'h5;
    localparam logic [11:0] RST_CONFIG_ONE  = 12'h000;
    localparam logic [11:0] RST_CONFIG_TWO  = 12'h000;
    localparam logic [11:0] RST_ALERT_FLAGS = 12'h000;
    localparam logic [11:0] RST_ALERT_LOW   = 12'h800;
    localparam logic [11:0] RST_ALERT_HIGH  = 12'h7FF;
    localparam int          STYLE_BIT       = 9;
    localparam int          RATIO_HI        = 8;
    localparam int          RATIO_LO        = 6;
    localparam int          CHECK_EN_BIT    = 5;
    localparam logic [11:0] CONFIG_ONE_MASK = 12'h3FD;
    localparam logic [2:0]  RATIO_OFF       = 3'h0;
    localparam logic [2:0]  RATIO_MAX_NORM  = 3'h5;
    localparam logic [2:0]  RATIO_MAX_ROLL  = 3'h3;

    typedef struct packed {
        logic        write_flag;
        logic [2:0]  register_select;
        logic [11:0] payload;
    } command_t;

    typedef struct packed {
        logic       averaging_style;
        logic [2:0] oversample_ratio;
        logic       ratio_enabled;
    } oversample_cfg_t;
endpackage

// ===== adc_reg_props.sv
// Concurrent checks on the register bank outputs
`timescale 1ns/10ps
module adc_reg_props (
    input wire logic                         clk_sys_i,
    input wire logic                         rst_i,
    input wire logic                         chip_select_n_i,
    input wire logic [11:0]                  config_one_o,
    input wire logic [11:0]                  config_two_o,
    input wire logic [11:0]                  alert_high_threshold_o,
    input wire adc_reg_pkg::oversample_cfg_t oversample_cfg_o,
    input wire logic                         frame_ignored_o
);
    import adc_reg_pkg::*;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // Writes land two edges after the last bit, so five idle cycles are safe
    sequence cs_quiet;
        chip_select_n_i [*5];
    endsequence
    sequence ign_seen;
        frame_ignored_o;
    endsequence

    cfg_reserved_a: assert property ((config_one_o & ~CONFIG_ONE_MASK) == 12'h000)
        else $error("config one reserved bits set");
    style_track_a: assert property (oversample_cfg_o.averaging_style == $past(config_one_o[STYLE_BIT]))
        else $error("averaging style does not follow config one");
    ratio_track_a: assert property (oversample_cfg_o.oversample_ratio == $past(config_one_o[8:6]))
        else $error("ratio does not follow config one");
    ratio_enable_a: assert property (oversample_cfg_o.ratio_enabled == ($past(config_one_o[8:6]) != RATIO_OFF &&
        $past(config_one_o[8:6]) <= ($past(config_one_o[9]) ? RATIO_MAX_ROLL : RATIO_MAX_NORM)))
        else $error("ratio enable wrong for style");
    ignore_pulse_a: assert property (ign_seen |=> !frame_ignored_o)
        else $error("ignored flag longer than one cycle");
    ignore_keep_a: assert property (ign_seen |-> (!config_one_o[CHECK_EN_BIT] && $stable(config_one_o)) [*3])
        else $error("ignored frame changed config one");
    idle_hold_a: assert property (cs_quiet |-> $stable(config_one_o) && $stable(config_two_o)
        && $stable(alert_high_threshold_o))
        else $error("register changed outside a frame");
    reset_vals_a: assert property ($fell(rst_i) |-> alert_high_threshold_o == RST_ALERT_HIGH
        && config_one_o == RST_CONFIG_ONE)
        else $error("wrong value after reset");
endmodule

// ===== adc_serial_register_access.sv
// Register bank behind the serial command port of a quad sampling converter
//
// Behaviour
// R01: A register frame lasts exactly 16 serial clock cycles.
// R02: Command bit 15 is write flag, 14..12 select, 11..0 payload.
// R03: Received bits 14..12 choose the addressed register.
// R04: Write flag 1 to a writable register loads the 12 payload bits; config one keeps bits 11, 10 and 1 at zero.
// R05: Write flag 0 is a read request and changes no register.
// R06: A valid read returns the register on the primary output next frame.
// R07: Reads of select 0, 6 or 7 are ignored; next frame returns conversions.
// R08: Reads aimed at write-only registers are ignored.
// R09: Writes to read-only registers are discarded.
// R10: Writes to no-operation and reserved addresses have no effect.
// R11: Reads of no-operation or reserved addresses give conversions next frame.
// R12: Config one bit 9 picks block (0) or rolling (1) averaging.
// R13: Config one bits 8..6 set ratio; 000 off; rolling allows 2, 4, 8 only.
// R14: Setting write-check bit 5 from 0 to 1 needs a valid check value.
// R15: Frames are MSB first and bounded by the active-low chip select.
// R16: Pending read target holds across the frame and clears after use.
`timescale 1ns/10ps
module adc_serial_register_access (
    input  wire logic                          clk_sys_i,
    input  wire logic                          rst_i,
    input  wire logic                          ce_i,
    input  wire logic                          chip_select_n_i,
    input  wire logic                          serial_clock_i,
    input  wire logic                          serial_command_in_i,
    input  wire logic                          check_valid_i,
    input  wire logic [adc_reg_pkg::FRAME_BITS-1:0] conversion_word_i,
    input  wire logic [11:0]                   alert_flags_i,
    output logic                               primary_serial_out_o,
    output logic [11:0]                        config_one_o,
    output logic [11:0]                        config_two_o,
    output logic [11:0]                        alert_high_threshold_o,
    output adc_reg_pkg::oversample_cfg_t       oversample_cfg_o,
    output logic                               frame_ignored_o
);
    import adc_reg_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FRAME = 2'b01,
        ST_WAIT  = 2'b11
    } frame_state_t;

    frame_state_t state;
    frame_state_t next_state;

    logic        sclk_q;
    logic        cs_n_q;
    logic [2:0]  pending_sel;
    logic        pending_valid;
    logic [11:0] alert_flags;
    logic [11:0] alert_low_threshold;
    logic        sdo_bit;
    logic [FRAME_BITS-1:0] cmd_word;
    logic        frame_done;

    // Inputs taken as synchronous; edges come from a one-cycle history
    wire sclk_rise    = serial_clock_i && !sclk_q;
    wire sclk_fall    = !serial_clock_i && sclk_q;
    wire frame_start  = !chip_select_n_i && cs_n_q;
    wire frame_active = !chip_select_n_i; // [R15]

    command_t cmd;
    assign cmd = command_t'(cmd_word); // [R02]

    // Select decode, reused for read and write sides
    function automatic logic sel_readable(input logic [2:0] sel);
        return sel inside {SEL_CONFIG_ONE, SEL_CONFIG_TWO, SEL_ALERT_FLAGS,
                           SEL_ALERT_LOW, SEL_ALERT_HIGH};
    endfunction

    function automatic logic sel_writable(input logic [2:0] sel);
        return sel inside {SEL_CONFIG_ONE, SEL_CONFIG_TWO, SEL_ALERT_HIGH};
    endfunction

    function automatic logic ratio_legal(input logic style, input logic [2:0] ratio);
        return style ? (ratio <= RATIO_MAX_ROLL) : (ratio <= RATIO_MAX_NORM);
    endfunction

    wire [2:0]  sel        = cmd.register_select;                     // [R03]
    wire        is_write   = frame_done && cmd.write_flag;
    wire        is_read    = frame_done && !cmd.write_flag;          // [R05]
    // Check bit rising needs a good check value, else the whole frame drops
    wire        check_rise = (sel == SEL_CONFIG_ONE) && cmd.payload[CHECK_EN_BIT]
                             && !config_one_o[CHECK_EN_BIT];
    wire        check_fail = is_write && check_rise && !check_valid_i; // [R14]
    wire        do_write   = is_write && sel_writable(sel) && !check_fail; // [R04] [R09] [R10]
    wire        read_ok    = is_read && sel_readable(sel);           // [R07] [R08] [R11]
    wire [11:0] cfg1_next  = cmd.payload & CONFIG_ONE_MASK;

    function automatic logic [11:0] reg_value(input logic [2:0] s,
                                              input logic [11:0] c1, input logic [11:0] c2,
                                              input logic [11:0] af, input logic [11:0] lo,
                                              input logic [11:0] hi);
        unique case (s)
            SEL_CONFIG_ONE:  return c1;
            SEL_CONFIG_TWO:  return c2;
            SEL_ALERT_FLAGS: return af;
            SEL_ALERT_LOW:   return lo;
            SEL_ALERT_HIGH:  return hi;
            default:         return 12'h000;
        endcase
    endfunction

    // Read answer echoes the select in bits 14..12, with bit 15 at zero
    wire [11:0] read_data = reg_value(pending_sel, config_one_o, config_two_o, alert_flags,
                                      alert_low_threshold, alert_high_threshold_o);
    wire [FRAME_BITS-1:0] out_word = pending_valid ? {1'b0, pending_sel, read_data} // [R06]
                                                   : conversion_word_i;            // [R07]

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:  if (frame_start) next_state = ST_FRAME;
            ST_FRAME: if (frame_done) next_state = ST_WAIT;
                      else if (chip_select_n_i) next_state = ST_IDLE;
            ST_WAIT:  if (chip_select_n_i) next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    cmd_shifter #(
        .FRAME_BITS     (FRAME_BITS)
    ) u_cmd (
        .clk_sys_i      (clk_sys_i),
        .rst_i          (rst_i),
        .ce_i           (ce_i),
        .frame_active_i (frame_active && state != ST_WAIT),
        .shift_i        (sclk_rise),
        .bit_i          (serial_command_in_i),
        .word_o         (cmd_word),
        .done_o         (frame_done)
    ); // [R01]

    out_shifter #(
        .FRAME_BITS     (FRAME_BITS)
    ) u_out (
        .clk_sys_i      (clk_sys_i),
        .rst_i          (rst_i),
        .ce_i           (ce_i),
        .load_i         (frame_start),
        .data_i         (out_word),
        .shift_i        (sclk_fall && frame_active),
        .bit_o          (sdo_bit)
    );

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state   <= ST_IDLE;
            sclk_q  <= 1'b0;
            cs_n_q  <= 1'b1;
        end else if (ce_i) begin
            state   <= next_state;
            sclk_q  <= serial_clock_i;
            cs_n_q  <= chip_select_n_i;
        end
    end

    // Pending read: set by a valid read, spent when the next frame loads it
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pending_valid <= 1'b0;
            pending_sel   <= 3'h0;
        end else if (ce_i) begin
            if (frame_done) begin
                pending_valid <= read_ok;                 // [R16]
                pending_sel   <= sel;
            end else if (frame_start) begin
                pending_valid <= 1'b0;                    // [R16]
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            config_one_o           <= RST_CONFIG_ONE;
            config_two_o           <= RST_CONFIG_TWO;
            alert_high_threshold_o <= RST_ALERT_HIGH;
        end else if (ce_i && do_write) begin
            unique case (sel)
                SEL_CONFIG_ONE: config_one_o <= cfg1_next; // [R04]
                SEL_CONFIG_TWO: config_two_o <= cmd.payload;
                SEL_ALERT_HIGH: alert_high_threshold_o <= cmd.payload;
                default:        config_two_o <= config_two_o;
            endcase
        end
    end

    // Read-only registers: flags mirrored from the core, low threshold fixed
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            alert_flags         <= RST_ALERT_FLAGS;
            alert_low_threshold <= RST_ALERT_LOW;
        end else if (ce_i) begin
            alert_flags         <= alert_flags_i; // [R09]
            alert_low_threshold <= RST_ALERT_LOW;
        end
    end

    // Ratio fields decoded once; a ratio out of range for the style is treated as off
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            oversample_cfg_o     <= '0;
            frame_ignored_o      <= 1'b0;
            primary_serial_out_o <= 1'b0;
        end else if (ce_i) begin
            oversample_cfg_o.averaging_style  <= config_one_o[STYLE_BIT];           // [R12]
            oversample_cfg_o.oversample_ratio <= config_one_o[RATIO_HI:RATIO_LO];   // [R13]
            oversample_cfg_o.ratio_enabled    <= (config_one_o[RATIO_HI:RATIO_LO] != RATIO_OFF)
                && ratio_legal(config_one_o[STYLE_BIT], config_one_o[RATIO_HI:RATIO_LO]); // [R13]
            frame_ignored_o      <= check_fail;
            primary_serial_out_o <= sdo_bit;
        end
    end
endmodule

// ===== adc_serial_register_access_tb.sv
// Self-checking bench for the serial register access block
`timescale 1ns/10ps
module adc_serial_register_access_tb;
    import adc_reg_pkg::*;
    logic            clk_sys_i = 1'b0;
    logic            rst_i = 1'b1;
    logic            check_valid_i = 1'b0;
    logic            ce_i = 1'b1;
    logic            cs_n, sck, serial_command_in, sdo, ignored;
    logic [11:0]     c1, c2, hi;
    oversample_cfg_t os_cfg;
    logic [15:0]     rx;
    int              fails = 0;
    int              compares = 0;
    int              ignored_seen = 0;
    // Command word, then the reply expected in the same frame
    logic [31:0]     rows [19] = '{32'h92C0A5C3, 32'h1000A5C3, 32'h200012C0, 32'hAABC2000, 32'hB123A5C3,
        32'hC456A5C3, 32'h8FFFA5C3, 32'hFFFFA5C3, 32'h3000A5C3, 32'h400035A3, 32'h50004800, 32'h000057FF,
        32'h6000A5C3, 32'h7000A5C3, 32'hD123A5C3, 32'h5000A5C3, 32'h10005123, 32'h000012C0, 32'h0000A5C3};

    always #20 clk_sys_i = ~clk_sys_i;

    adc_serial_register_access adc_serial_register_access_inst (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .chip_select_n_i(cs_n), .serial_clock_i(sck),
        .serial_command_in_i(serial_command_in), .check_valid_i(check_valid_i), .conversion_word_i(16'hA5C3),
        .alert_flags_i(12'h5A3), .primary_serial_out_o(sdo), .config_one_o(c1), .config_two_o(c2),
        .alert_high_threshold_o(hi), .oversample_cfg_o(os_cfg), .frame_ignored_o(ignored));
    spi_host_model spi_host_model_inst (
        .clk_sys_i(clk_sys_i), .primary_serial_out_i(sdo), .chip_select_n_o(cs_n),
        .serial_clock_o(sck), .serial_command_in_o(serial_command_in));

    always @(posedge clk_sys_i) begin
        if (ignored === 1'b1) begin
            ignored_seen <= ignored_seen + 1;
        end
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_reset;
        cmp({4'h0, c1}, 16'h0000);
        cmp({4'h0, c2}, 16'h0000);
        cmp({4'h0, hi}, {4'h0, RST_ALERT_HIGH});
        cmp({10'h000, os_cfg, ignored}, 16'h0000);
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Limit of about 83 frames of some 120 cycles each; the test runs 27
    initial begin
        #400000;
        fails++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        check_reset();
        foreach (rows[i]) begin
            spi_host_model_inst.run_frame(rows[i][31:16], rx);
            cmp(rx, rows[i][15:0]);
        end
        cmp({4'h0, c1}, 16'h02C0);
        cmp({4'h0, c2}, 16'h0ABC);
        cmp({4'h0, hi}, 16'h0123);
        cmp({11'h000, os_cfg}, {11'h000, 1'b1, 3'h3, 1'b1});
        // Check bit rising without a valid check value drops the frame
        spi_host_model_inst.run_frame(16'h92E0, rx);
        cmp({4'h0, c1}, 16'h02C0);
        cmp(ignored_seen[15:0], 16'h0001);
        check_valid_i <= 1'b1;
        spi_host_model_inst.run_frame(16'h92E0, rx);
        cmp({4'h0, c1}, 16'h02E0);
        spi_host_model_inst.run_frame(16'h9320, rx);
        cmp({11'h000, os_cfg}, {11'h000, 1'b1, 3'h4, 1'b0});
        // Block averaging reaches 32x; codes above it read as off
        spi_host_model_inst.run_frame(16'h9160, rx);
        cmp({11'h000, os_cfg}, {11'h000, 1'b0, 3'h5, 1'b1});
        spi_host_model_inst.run_frame(16'h91A0, rx);
        cmp({11'h000, os_cfg}, {11'h000, 1'b0, 3'h6, 1'b0});
        // Clock enable low freezes the port, so this write must not land
        ce_i <= 1'b0;
        spi_host_model_inst.run_frame(16'hD456, rx);
        ce_i <= 1'b1;
        spi_host_model_inst.run_frame(16'h5000, rx);
        spi_host_model_inst.run_frame(16'h0000, rx);
        cmp(rx, 16'h5123);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        check_reset();
        stop_test();
    end
endmodule

bind adc_serial_register_access adc_reg_props adc_reg_props_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .chip_select_n_i(chip_select_n_i), .config_one_o(config_one_o),
    .config_two_o(config_two_o), .alert_high_threshold_o(alert_high_threshold_o),
    .oversample_cfg_o(oversample_cfg_o), .frame_ignored_o(frame_ignored_o));

// ===== cmd_shifter.sv
// Serial-in command shifter, counts frame bits and flags frame completion
`timescale 1ns/10ps
module cmd_shifter #(
    parameter int FRAME_BITS = 16
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  frame_active_i,
    input  wire logic                  shift_i,
    input  wire logic                  bit_i,
    output logic [FRAME_BITS-1:0]      word_o,
    output logic                       done_o
);
    import adc_reg_pkg::*;

    logic [CNT_W-1:0] count;
    wire              last_bit = (count == FRAME_LAST);

    // MSB first: new bits enter at the bottom
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            word_o <= '0;
            count  <= '0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= frame_active_i && shift_i && last_bit;
            if (!frame_active_i) begin
                count <= '0;
            end else if (shift_i && count <= FRAME_LAST) begin
                word_o <= {word_o[FRAME_BITS-2:0], bit_i};
                count  <= count + 5'h01;
            end
        end
    end
endmodule

// ===== out_shifter.sv
// Parallel-load serial-out shifter for the primary serial output
`timescale 1ns/10ps
module out_shifter #(
    parameter int FRAME_BITS = 16
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  load_i,
    input  wire logic [FRAME_BITS-1:0] data_i,
    input  wire logic                  shift_i,
    output logic                       bit_o
);
    logic [FRAME_BITS-1:0] shreg;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            shreg <= '0;
            bit_o <= 1'b0;
        end else if (ce_i) begin
            if (load_i) begin
                shreg <= {data_i[FRAME_BITS-2:0], 1'b0};
                bit_o <= data_i[FRAME_BITS-1];
            end else if (shift_i) begin
                shreg <= {shreg[FRAME_BITS-2:0], 1'b0};
                bit_o <= shreg[FRAME_BITS-1];
            end
        end
    end
endmodule

// ===== spi_host_model.sv
// Serial host that runs 16-bit command frames and captures the reply
`timescale 1ns/10ps
module spi_host_model (
    input  wire logic clk_sys_i,
    input  wire logic primary_serial_out_i,
    output logic      chip_select_n_o,
    output logic      serial_clock_o,
    output logic      serial_command_in_o
);
    initial begin
        chip_select_n_o = 1'b1;
        serial_clock_o = 1'b0;
        serial_command_in_o = 1'b0;
    end

    // Half periods of three or four clocks stay above the two-cycle sampling floor
    task automatic run_frame(input logic [15:0] cmd, output logic [15:0] rx);
        chip_select_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_command_in_o <= cmd[i];
            repeat (4) @(posedge clk_sys_i);
            rx[i] = primary_serial_out_i;
            serial_clock_o <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
            serial_clock_o <= 1'b0;
        end
        repeat (3) @(posedge clk_sys_i);
        chip_select_n_o <= 1'b1;
        // Released line must not keep showing the last bit
        serial_command_in_o <= ~cmd[0];
        repeat (3) @(posedge clk_sys_i);
    endtask
endmodule
